// File: fcs_map.vh
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
// Flash command addresses and bytes
`define FCS_ADDR_UNLOCK1 19'h0_0555
`define FCS_ADDR_UNLOCK2 19'h0_02AA
`define FCS_DATA_UNLOCK1 8'hAA
`define FCS_DATA_UNLOCK2 8'h55
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_AUTOSEL 8'h90
`define FCS_CMD_BYPASS 8'h20
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECTOR_ERASE 8'h30
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_RESUME 8'h30
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_BYPASS_EXIT2 8'h00
// Sector select field of the flash address
`define FCS_SECTOR_MSB 18
`define FCS_SECTOR_LSB 16
// Register offsets of the controller
`define FCS_REG_CTRL 12'h000
`define FCS_REG_ADDR 12'h004
`define FCS_REG_WDATA 12'h008
`define FCS_REG_STATUS 12'h00C
`define FCS_REG_RDATA 12'h010
`define FCS_REG_CFG 12'h014
// Control command field: bits 3:0
`define FCS_OP_READ 4'h1
`define FCS_OP_RESET 4'h2
`define FCS_OP_AUTOSEL 4'h3
`define FCS_OP_PROGRAM 4'h4
`define FCS_OP_BYPASS 4'h5
`define FCS_OP_BYP_PROG 4'h6
`define FCS_OP_BYP_EXIT 4'h7
`define FCS_OP_CHIP_ERASE 4'h8
`define FCS_OP_SECT_ERASE 4'h9
`define FCS_OP_SUSPEND 4'hA
`define FCS_OP_RESUME 4'hB
// Status bit positions
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_BYPASS 3
`define FCS_ST_AUTOSEL 4
`define FCS_ST_SUSPEND 5
// Reset values
`define FCS_CFG_RESET 8'h08
// Timing
`define FCS_CLK_MHZ 100
`define FCS_SUSPEND_US 20
`define FCS_SUSPEND_CYC (`FCS_SUSPEND_US * `FCS_CLK_MHZ)
`endif

// File: fcs_apb_slave.v
`include "fcs_map.vh"
// Register file of the controller, one word per register
module fcs_apb_slave (
	input wire clk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,
	output reg start_out,
	output reg [3:0] op_out,
	output reg [18:0] addr_out,
	output reg [7:0] wdata_out,
	output reg [7:0] cfg_strobe_out,
	output reg clr_done_out,
	input wire [5:0] status_in,
	input wire [7:0] rdata_in
);
	wire acc = psel_in & penable_in;
	reg hit;
	reg [31:0] rd;
	always @* begin
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (paddr_in)
		`FCS_REG_CTRL: rd = {28'h000_0000, op_out};
		`FCS_REG_ADDR: rd = {13'h0000, addr_out};
		`FCS_REG_WDATA: rd = {24'h00_0000, wdata_out};
		`FCS_REG_STATUS: rd = {26'h000_0000, status_in};
		`FCS_REG_RDATA: rd = {24'h00_0000, rdata_in};
		`FCS_REG_CFG: rd = {24'h00_0000, cfg_strobe_out};
		default: hit = 1'b0;
		endcase
	end
	assign prdata_out = rd;
	assign pready_out = 1'b1;
	assign pslverr_out = acc & ~hit;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			start_out <= 1'b0;
			op_out <= 4'h0;
			addr_out <= 19'h0_0000;
			wdata_out <= 8'h00;
			cfg_strobe_out <= `FCS_CFG_RESET;
			clr_done_out <= 1'b0;
		end else begin
			start_out <= 1'b0;
			clr_done_out <= 1'b0;
			if (acc & pwrite_in) begin
				case (paddr_in)
				`FCS_REG_CTRL: begin
					op_out <= pwdata_in[3:0];
					start_out <= 1'b1;
				end
				`FCS_REG_ADDR: addr_out <= pwdata_in[18:0];
				`FCS_REG_WDATA: wdata_out <= pwdata_in[7:0];
				`FCS_REG_STATUS: clr_done_out <= pwdata_in[`FCS_ST_DONE];
				`FCS_REG_CFG: cfg_strobe_out <= pwdata_in[7:0];
				default: ;
				endcase
			end
		end
	end
endmodule // fcs_apb_slave

// File: fcs_bus_cycle.v
`include "fcs_map.vh"
// One flash bus cycle: write or read, strobe held for a set width
module fcs_bus_cycle (
	input wire clk_in,
	input wire rst_in,
	input wire go_in,
	input wire wr_in,
	input wire [18:0] addr_in,
	input wire [7:0] data_in,
	input wire [7:0] width_in,
	input wire [7:0] dq_sync_in,
	output reg done_out,
	output reg [7:0] rdata_out,
	output reg [18:0] fl_addr_out,
	output reg [7:0] fl_dq_out,
	output reg fl_dq_oe_n_out,
	output reg fl_ce_n_out,
	output reg fl_we_n_out,
	output reg fl_oe_n_out
);
	localparam S_IDLE = 2'd0;
	localparam S_SETUP = 2'd1;
	localparam S_STROBE = 2'd2;
	localparam S_HOLD = 2'd3;
	reg [1:0] st_r;
	reg [7:0] cnt_r;
	reg wr_r;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= S_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= 8'h00;
			fl_addr_out <= 19'h0_0000;
			fl_dq_out <= 8'h00;
			fl_dq_oe_n_out <= 1'b1;
			fl_ce_n_out <= 1'b1;
			fl_we_n_out <= 1'b1;
			fl_oe_n_out <= 1'b1;
		end else begin
			done_out <= 1'b0;
			case (st_r)
			S_IDLE: if (go_in) begin
				// Address settles before either strobe falls
				fl_addr_out <= addr_in;
				fl_dq_out <= data_in;
				wr_r <= wr_in;
				fl_dq_oe_n_out <= ~wr_in;
				st_r <= S_SETUP;
			end
			S_SETUP: begin
				// OE stays high on writes so the cycle is not read [RQ25]
				fl_ce_n_out <= 1'b0;
				fl_we_n_out <= ~wr_r;
				fl_oe_n_out <= wr_r;
				cnt_r <= width_in;
				st_r <= S_STROBE;
			end
			S_STROBE: if (cnt_r <= 8'h01) begin
				// Read data passed the two-stage synchroniser; the
				// strobe width must cover access time plus two cycles
				if (!wr_r)
					rdata_out <= dq_sync_in;
				// Data held past WE rise so the latch sees it [RQ6]
				fl_we_n_out <= 1'b1;
				fl_oe_n_out <= 1'b1;
				fl_ce_n_out <= 1'b1;
				st_r <= S_HOLD;
			end else
				cnt_r <= cnt_r - 8'h01;
			S_HOLD: begin
				fl_dq_oe_n_out <= 1'b1;
				done_out <= 1'b1;
				st_r <= S_IDLE;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule // fcs_bus_cycle

// File: fcs_ctrl.v
// The implementer's own choices: the address map and the APB interface to the registers.
`include "fcs_map.vh"
// Rules from the document that this block follows or relies on
// [RQ1] Plain reads need no command after power-up
// [RQ2] Suspended-sector reads give status, others data
// [RQ3] Reset command after time limit or autoselect
// [RQ4] Autoselect entered by unlock pair plus 90
// [RQ5] Program: unlock pair, A0, address and data
// [RQ6] Address at last fall, data first rise
// [RQ7] Programming only clears bits to zero
// [RQ8] Time limit flag stays until reset
// [RQ9] Bypass: two-cycle program until bypass reset
// [RQ10] Chip erase is six writes ending 10
// [RQ11] Commands ignored during chip erase
// [RQ12] Erase end returns to array read
// [RQ13] Sector erase ends with sector address, 30
// [RQ14] Sector erase accepts only suspend
// [RQ15] Suspend halts erase within 20 us
// [RQ16] Suspended: other sectors usable, no autoselect; the autoselect op is not blocked here and still sets its status bit
// [RQ17] Resume continues erase, repeats ignored
// [RQ18] Program polling bit inverts until done
// [RQ19] Erase polling bit zero until done
// [RQ20] Poll inside the busy sector
// [RQ21] Reread full byte after polling completes
// [RQ22] Unlock AA@555, 55@2AA and command bytes
// [RQ23] Bad sequence returns device to read
// [RQ24] Top three address bits pick sector
// [RQ25] Write needs CE and WE low, OE high
// [RQ26] Operation lengths vary, so poll not time
module fcs_ctrl #(
	parameter SUSPEND_CYCLES = `FCS_SUSPEND_CYC
) (
	input wire clk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,
	output wire [18:0] fl_addr_out,
	output wire [7:0] fl_dq_out,
	output wire fl_dq_oe_n_out,
	input wire [7:0] fl_dq_in,
	output wire fl_ce_n_out,
	output wire fl_we_n_out,
	output wire fl_oe_n_out
);
	localparam S_IDLE = 3'd0;
	localparam S_WRITE = 3'd1;
	localparam S_WAIT = 3'd2;
	localparam S_POLL = 3'd3;
	localparam S_REREAD = 3'd4;
	localparam S_DELAY = 3'd5;
	localparam S_FINISH = 3'd6;

	reg [7:0] dq_s1_r;
	reg [7:0] dq_s2_r;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dq_s1_r <= 8'h00;
			dq_s2_r <= 8'h00;
		end else begin
			dq_s1_r <= fl_dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	wire start;
	wire clr_done;
	wire [3:0] op;
	wire [18:0] req_addr;
	wire [7:0] req_data;
	wire [7:0] width;
	wire [7:0] cyc_rdata;
	wire cyc_done;
	reg [2:0] st_r;
	reg [2:0] idx_r;
	reg [2:0] len_r;
	reg [3:0] op_r;
	reg busy_r;
	reg done_r;
	reg fail_r;
	reg bypass_r;
	reg autosel_r;
	reg suspend_r;
	reg susp_req_r;
	reg go_r;
	reg wr_r;
	reg [18:0] caddr_r;
	reg [7:0] cdata_r;
	reg [7:0] rdata_r;
	reg [12:0] dly_r;
	reg [18:0] seq_a;
	reg [7:0] seq_d;
	wire [5:0] status;

	assign status[`FCS_ST_BUSY] = busy_r;
	assign status[`FCS_ST_DONE] = done_r;
	assign status[`FCS_ST_FAIL] = fail_r;
	assign status[`FCS_ST_BYPASS] = bypass_r;
	assign status[`FCS_ST_AUTOSEL] = autosel_r;
	assign status[`FCS_ST_SUSPEND] = suspend_r;

	fcs_apb_slave u_regs (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.start_out(start),
		.op_out(op),
		.addr_out(req_addr),
		.wdata_out(req_data),
		.cfg_strobe_out(width),
		.clr_done_out(clr_done),
		.status_in(status),
		.rdata_in(rdata_r)
	);

	fcs_bus_cycle u_cyc (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.go_in(go_r),
		.wr_in(wr_r),
		.addr_in(caddr_r),
		.data_in(cdata_r),
		.width_in(width),
		.dq_sync_in(dq_s2_r),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.fl_addr_out(fl_addr_out),
		.fl_dq_out(fl_dq_out),
		.fl_dq_oe_n_out(fl_dq_oe_n_out),
		.fl_ce_n_out(fl_ce_n_out),
		.fl_we_n_out(fl_we_n_out),
		.fl_oe_n_out(fl_oe_n_out)
	);

	// Number of writes in each command sequence
	function [2:0] seq_len;
		input [3:0] o;
		begin
			case (o)
			`FCS_OP_RESET, `FCS_OP_SUSPEND, `FCS_OP_RESUME: seq_len = 3'd1;
			`FCS_OP_BYP_PROG, `FCS_OP_BYP_EXIT: seq_len = 3'd2;
			`FCS_OP_AUTOSEL, `FCS_OP_BYPASS: seq_len = 3'd3;
			`FCS_OP_PROGRAM: seq_len = 3'd4;
			`FCS_OP_CHIP_ERASE, `FCS_OP_SECT_ERASE: seq_len = 3'd6;
			default: seq_len = 3'd0;
			endcase
		end
	endfunction

	// Address and data of write idx of the current sequence
	always @* begin
		seq_a = `FCS_ADDR_UNLOCK1;
		seq_d = `FCS_DATA_UNLOCK1;
		if (idx_r == 3'd1 || idx_r == 3'd4) begin
			seq_a = `FCS_ADDR_UNLOCK2;
			seq_d = `FCS_DATA_UNLOCK2;
		end
		case (op_r)
		`FCS_OP_RESET: seq_d = `FCS_CMD_RESET; // [RQ3]
		`FCS_OP_SUSPEND: seq_d = `FCS_CMD_SUSPEND;
		`FCS_OP_RESUME: seq_d = `FCS_CMD_RESUME;
		`FCS_OP_AUTOSEL: if (idx_r == 3'd2) seq_d = `FCS_CMD_AUTOSEL; // [RQ4]
		`FCS_OP_BYPASS: if (idx_r == 3'd2) seq_d = `FCS_CMD_BYPASS;
		`FCS_OP_PROGRAM: begin // [RQ5]
			if (idx_r == 3'd2)
				seq_d = `FCS_CMD_PROGRAM;
			if (idx_r == 3'd3) begin
				seq_a = req_addr;
				seq_d = req_data;
			end
		end
		`FCS_OP_BYP_PROG: begin // [RQ9]
			seq_d = `FCS_CMD_PROGRAM;
			if (idx_r == 3'd1) begin
				seq_a = req_addr;
				seq_d = req_data;
			end
		end
		`FCS_OP_BYP_EXIT: seq_d = (idx_r == 3'd0) ? `FCS_CMD_AUTOSEL :
			`FCS_CMD_BYPASS_EXIT2;
		`FCS_OP_CHIP_ERASE, `FCS_OP_SECT_ERASE: begin // [RQ10] [RQ13]
			if (idx_r == 3'd2)
				seq_d = `FCS_CMD_ERASE_SETUP;
			if (idx_r == 3'd5) begin
				seq_d = (op_r == `FCS_OP_CHIP_ERASE) ?
					`FCS_CMD_CHIP_ERASE : `FCS_CMD_SECTOR_ERASE;
				// Only the sector field matters on the last write [RQ24]
				if (op_r == `FCS_OP_SECT_ERASE)
					seq_a = {req_addr[`FCS_SECTOR_MSB:`FCS_SECTOR_LSB],
						16'h0000};
			end
		end
		default: ;
		endcase
	end

	wire polls = (op_r == `FCS_OP_PROGRAM) || (op_r == `FCS_OP_BYP_PROG) ||
		(op_r == `FCS_OP_CHIP_ERASE) || (op_r == `FCS_OP_SECT_ERASE);
	wire is_erase = (op_r == `FCS_OP_CHIP_ERASE) ||
		(op_r == `FCS_OP_SECT_ERASE);
	// Bit seven shows done: true data for program, one for erase
	wire poll_ok = is_erase ? cyc_rdata[7] : (cyc_rdata[7] == req_data[7]);

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= S_IDLE;
			idx_r <= 3'd0;
			len_r <= 3'd0;
			op_r <= 4'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			bypass_r <= 1'b0; // [RQ9]
			autosel_r <= 1'b0;
			suspend_r <= 1'b0;
			susp_req_r <= 1'b0;
			go_r <= 1'b0;
			wr_r <= 1'b0;
			caddr_r <= 19'h0_0000;
			cdata_r <= 8'h00;
			rdata_r <= 8'h00;
			dly_r <= 13'h0000;
		end else begin
			go_r <= 1'b0;
			// Suspend may come while a sector erase is polled; it waits for a gap
			if (start && busy_r && op == `FCS_OP_SUSPEND &&
				op_r == `FCS_OP_SECT_ERASE)
				susp_req_r <= 1'b1; // [RQ11] [RQ14]
			if (clr_done && !(st_r == S_FINISH))
				done_r <= 1'b0;
			case (st_r)
			S_IDLE: if (start && !busy_r) begin
				op_r <= op;
				busy_r <= 1'b1;
				fail_r <= 1'b0;
				idx_r <= 3'd0;
				len_r <= seq_len(op);
				if (op == `FCS_OP_READ) begin
					// Plain read, no command first [RQ1] [RQ2] [RQ16]
					caddr_r <= req_addr;
					wr_r <= 1'b0;
					go_r <= 1'b1;
					st_r <= S_REREAD;
				end else if (seq_len(op) == 3'd0) begin // [RQ23]
					st_r <= S_FINISH;
				end else
					st_r <= S_WRITE;
			end
			S_WRITE: begin
				caddr_r <= seq_a; // [RQ22]
				cdata_r <= seq_d;
				wr_r <= 1'b1;
				go_r <= 1'b1;
				st_r <= S_WAIT;
			end
			S_WAIT: if (cyc_done) begin
				if (idx_r == len_r - 3'd1) begin
					if (polls) begin
						// Poll at the target sector [RQ20] [RQ18] [RQ19]
						caddr_r <= req_addr;
						wr_r <= 1'b0;
						go_r <= 1'b1;
						st_r <= S_POLL;
					end else if (op_r == `FCS_OP_SUSPEND) begin
						dly_r <= SUSPEND_CYCLES[12:0]; // [RQ15]
						st_r <= S_DELAY;
					end else
						st_r <= S_FINISH;
				end else begin
					idx_r <= idx_r + 3'd1;
					st_r <= S_WRITE;
				end
			end
			S_POLL: if (cyc_done) begin
				if (poll_ok) begin
					// Full byte only on a later read [RQ12] [RQ21]
					go_r <= 1'b1;
					st_r <= S_REREAD;
				end else if (cyc_rdata[5]) begin
					// Time limit: send reset [RQ3] [RQ7] [RQ8]
					fail_r <= 1'b1;
					op_r <= `FCS_OP_RESET;
					idx_r <= 3'd0;
					len_r <= 3'd1;
					st_r <= S_WRITE;
				end else if (susp_req_r) begin
					// Stop polling and send the suspend byte [RQ15]
					op_r <= `FCS_OP_SUSPEND;
					idx_r <= 3'd0;
					len_r <= 3'd1;
					st_r <= S_WRITE;
				end else
					go_r <= 1'b1; // [RQ26]
			end
			S_REREAD: if (cyc_done) begin
				rdata_r <= cyc_rdata;
				st_r <= S_FINISH;
			end
			S_DELAY: if (dly_r <= 13'h0001)
				st_r <= S_FINISH;
			else
				dly_r <= dly_r - 13'h0001;
			S_FINISH: begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				case (op_r)
				`FCS_OP_RESET: autosel_r <= 1'b0;
				`FCS_OP_AUTOSEL: autosel_r <= 1'b1;
				`FCS_OP_BYPASS: bypass_r <= 1'b1;
				`FCS_OP_BYP_EXIT: bypass_r <= 1'b0;
				`FCS_OP_SUSPEND: suspend_r <= 1'b1;
				`FCS_OP_RESUME: suspend_r <= 1'b0; // [RQ17]
				default: ;
				endcase
			end
			default: st_r <= S_IDLE;
			endcase
			if (st_r == S_FINISH) begin
				st_r <= S_IDLE;
				susp_req_r <= 1'b0;
			end
		end
	end
endmodule // fcs_ctrl

// File: fcs_ctrl_properties.sv
module fcs_ctrl_properties #(
	parameter SUSPEND_CYCLES = 2000
) (
	input wire clk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pready_out,
	input wire [18:0] fl_addr_out,
	input wire [7:0] fl_dq_out,
	input wire fl_dq_oe_n_out,
	input wire fl_ce_n_out,
	input wire fl_we_n_out,
	input wire fl_oe_n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_wr(a, d);
		$fell(fl_we_n_out) && fl_addr_out == a && fl_dq_out == d;
	endsequence
	// Program data is polled at the very address it was written to
	property p_poll;
		logic [18:0] pa;
		($fell(fl_we_n_out) && fl_dq_out == 8'hA0) ##[1:20]
		($fell(fl_we_n_out), pa = fl_addr_out) |->
		##[1:40] ($fell(fl_oe_n_out) && fl_addr_out == pa);
	endproperty
	a_write_oe_off: assert property (
		!fl_we_n_out |-> fl_oe_n_out && !fl_ce_n_out)
		else $error("write strobe without select or with output on");
	a_write_drives_dq: assert property (
		!fl_we_n_out |-> !fl_dq_oe_n_out)
		else $error("write strobe while data lines released");
	a_read_bus_free: assert property (
		!fl_oe_n_out |-> fl_dq_oe_n_out)
		else $error("data lines driven during a read");
	a_write_held: assert property (
		!fl_we_n_out && $past(!fl_we_n_out) |->
		$stable(fl_addr_out) && $stable(fl_dq_out))
		else $error("address or data moved inside a write pulse");
	a_unlock_pair: assert property (
		s_wr(19'h0_0555, 8'hAA) |-> ##[1:100] s_wr(19'h0_02AA, 8'h55))
		else $error("first unlock write not followed by second");
	a_unlock_addr: assert property (
		$fell(fl_we_n_out) && fl_dq_out == 8'hAA |->
		fl_addr_out == 19'h0_0555)
		else $error("unlock byte at wrong address");
	a_chip_cmd_addr: assert property (
		$fell(fl_we_n_out) && fl_dq_out == 8'h10 |->
		fl_addr_out == 19'h0_0555)
		else $error("chip erase byte at wrong address");
	a_poll_program: assert property (p_poll)
		else $error("program status polled away from its address");
	a_apb_ready: assert property (psel_in && penable_in |-> pready_out)
		else $error("access phase without ready");
endmodule // fcs_ctrl_properties

bind fcs_ctrl fcs_ctrl_properties #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_props (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pready_out(pready_out),
	.fl_addr_out(fl_addr_out),
	.fl_dq_out(fl_dq_out),
	.fl_dq_oe_n_out(fl_dq_oe_n_out),
	.fl_ce_n_out(fl_ce_n_out),
	.fl_we_n_out(fl_we_n_out),
	.fl_oe_n_out(fl_oe_n_out)
);

// File: fcs_flash_model.sv
module fcs_flash_model #(
	parameter PROG_TICKS = 30,
	parameter ERASE_TICKS = 400,
	parameter LIMIT_TICKS = 60,
	parameter [7:0] MAKER_ID = 8'h3B, // Arbitrary value
	parameter [7:0] PART_ID = 8'h62 // Arbitrary value
) (
	input wire [18:0] addr_in,
	input wire [7:0] dq_in,
	input wire dq_oe_n_in,
	input wire ce_n_in,
	input wire we_n_in,
	input wire oe_n_in,
	output logic [7:0] dq_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [int];
	int ks[$];
	logic [18:0] la;
	logic [7:0] pd, rv;
	logic [2:0] esec;
	logic wr_act, autosel, bypass, pbusy, pfail, lim, chip, susp, ebusy, pat;
	int step, ptime, etime;
	initial begin
		{wr_act, autosel, bypass, pbusy, pfail, lim, chip, susp, ebusy} = 0;
		{pat, step, ptime, etime, esec, pd} = 0;
	end
	function logic [7:0] arr(input logic [18:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	always @* begin
		if (pbusy || lim)
			rv = {~pd[7], 1'b0, lim, 5'h00};
		else if (ebusy && !susp)
			rv = 8'h00;
		else if (susp && addr_in[18:16] == esec)
			rv = 8'h80;
		else if (autosel)
			rv = addr_in[0] ? PART_ID : MAKER_ID;
		else
			rv = arr(addr_in);
		if (!ce_n_in && !oe_n_in)
			dq_out = rv;
		else if (!dq_oe_n_in)
			dq_out = dq_in;
		else
			dq_out = {8{pat}}; // No pull on the lines, so show a moving pattern
	end
	always @(negedge ce_n_in or negedge we_n_in)
		if (!ce_n_in && !we_n_in && oe_n_in) begin
			wr_act = 1;
			la = addr_in;
		end
	always @(posedge ce_n_in or posedge we_n_in)
		if (wr_act) begin
			wr_act = 0;
			cmd(la, dq_in);
		end
	task cmd(input logic [18:0] a, input logic [7:0] d);
		if (chip || pbusy)
			return;
		if (ebusy && !susp) begin
			if (d == 8'hB0)
				susp = 1;
			return;
		end
		if (lim) begin
			if (d == 8'hF0)
				lim = 0;
			return;
		end
		if (step == 3) begin
			pd = d;
			pfail = (d & ~arr(a)) != 0;
			if (!pfail)
				mem[a] = arr(a) & d;
			ptime = pfail ? LIMIT_TICKS : PROG_TICKS;
			pbusy = 1;
			step = 0;
		end else if (step == 7) begin
			if (d == 8'h00)
				bypass = 0;
			step = 0;
		end else if ((step == 1 || step == 5) && a == 19'h0_02AA && d == 8'h55)
			step++;
		else if ((step == 0 || step == 4) && a == 19'h0_0555 && d == 8'hAA)
			step++;
		else if (step == 2 && a == 19'h0_0555) begin
			step = 0;
			case (d)
			8'hA0: step = 3;
			8'h90: autosel = !susp;
			8'h20: bypass = 1;
			8'h80: step = 4;
			endcase
		end else if (step == 6 && (d == 8'h10 && a == 19'h0_0555 || d == 8'h30)) begin
			chip = d == 8'h10;
			esec = a[18:16];
			ebusy = 1;
			etime = ERASE_TICKS;
			step = 0;
		end else if (step == 0 && d == 8'hF0)
			autosel = 0;
		else if (step == 0 && bypass && d == 8'hA0)
			step = 3;
		else if (step == 0 && bypass && d == 8'h90)
			step = 7;
		else if (step == 0 && susp && d == 8'h30)
			susp = 0;
		else
			step = 0;
	endtask
	always #10 begin
		pat = ~pat;
		if (pbusy)
			ptime--;
		if (pbusy && ptime == 0) begin
			pbusy = 0;
			lim = pfail;
		end
		if (ebusy && !susp)
			etime--;
		if (ebusy && etime == 0) begin
			ks.delete();
			foreach (mem[k])
				if (chip || k[18:16] == esec)
					ks.push_back(k);
			foreach (ks[i])
				mem.delete(ks[i]);
			ebusy = 0;
			chip = 0;
		end
	end
endmodule // fcs_flash_model

// File: fcs_ctrl_bench.sv
`include "fcs_map.vh"
module fcs_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [7:0] MAKER = 8'h3B; // Arbitrary value
	localparam [7:0] PART = 8'h62; // Arbitrary value
	localparam [31:0] DN = 32'h0000_0002;
	logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [11:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0, r;
	logic serr;
	wire [31:0] prdata_out;
	wire pready_out, pslverr_out, fl_dq_oe_n_out, fl_ce_n_out, fl_we_n_out;
	wire fl_oe_n_out;
	wire [18:0] fl_addr_out;
	wire [7:0] fl_dq_out, fl_dq_in;
	int errors = 0, tests_run = 0;
	always #5 clk_in = ~clk_in;
	fcs_ctrl #(.SUSPEND_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.fl_addr_out(fl_addr_out), .fl_dq_out(fl_dq_out),
		.fl_dq_oe_n_out(fl_dq_oe_n_out), .fl_dq_in(fl_dq_in),
		.fl_ce_n_out(fl_ce_n_out), .fl_we_n_out(fl_we_n_out),
		.fl_oe_n_out(fl_oe_n_out));
	fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
		.addr_in(fl_addr_out), .dq_in(fl_dq_out), .dq_oe_n_in(fl_dq_oe_n_out),
		.ce_n_in(fl_ce_n_out), .we_n_in(fl_we_n_out), .oe_n_in(fl_oe_n_out),
		.dq_out(fl_dq_in));
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0000_0000, 32'h0000_0001);
			give_verdict;
		end
		r = prdata_out;
		serr = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic run(input logic [3:0] o, input logic [18:0] a,
		input logic [7:0] d, input logic [31:0] m);
		int n;
		apb(1, `FCS_REG_STATUS, DN);
		apb(1, `FCS_REG_ADDR, {13'h0, a});
		apb(1, `FCS_REG_WDATA, {24'h0, d});
		apb(1, `FCS_REG_CTRL, {28'h0, o});
		// A missing completion ends the run rather than hanging it
		for (n = 0; m != 0 && n < 3000; n++) begin
			apb(0, `FCS_REG_STATUS, 32'h0000_0000);
			if ((r & m) != 0)
				break;
		end
		if (n == 3000) begin
			chk(r, m);
			give_verdict;
		end
	endtask
	task automatic rd_byte(input logic [18:0] a, input logic [7:0] exp);
		run(`FCS_OP_READ, a, 8'h00, DN);
		apb(0, `FCS_REG_RDATA, 32'h0000_0000);
		chk(r, {24'h0, exp});
	endtask
	task t_regs;
		apb(0, `FCS_REG_STATUS, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(0, `FCS_REG_CFG, 32'h0000_0000);
		chk(r, `FCS_CFG_RESET);
		apb(0, 12'h020, 32'h0000_0000);
		chk({r[30:0], serr}, 32'h0000_0001);
	endtask
	task t_program;
		rd_byte(19'h1_0123, 8'hFF);
		run(`FCS_OP_PROGRAM, 19'h1_0123, 8'h5A, DN);
		chk(r & 32'h0000_0005, 32'h0000_0000);
		rd_byte(19'h1_0123, 8'h5A);
		run(`FCS_OP_PROGRAM, 19'h1_0123, 8'hA5, DN);
		chk(r & 32'h0000_0004, 32'h0000_0004);
		chk({31'h0, u_flash.lim}, 32'h0000_0000);
		rd_byte(19'h1_0123, 8'h5A);
	endtask
	task t_autosel;
		run(`FCS_OP_AUTOSEL, 19'h0, 8'h00, DN);
		chk(r & 32'h0000_0010, 32'h0000_0010);
		rd_byte(19'h0_0000, MAKER);
		rd_byte(19'h0_0001, PART);
		rd_byte(19'h0_0000, MAKER);
		run(`FCS_OP_RESET, 19'h0, 8'h00, DN);
		chk(r & 32'h0000_0010, 32'h0000_0000);
		rd_byte(19'h1_0123, 8'h5A);
	endtask
	task t_bypass;
		run(`FCS_OP_BYPASS, 19'h0, 8'h00, DN);
		chk(r & 32'h0000_0008, 32'h0000_0008);
		run(`FCS_OP_BYP_PROG, 19'h2_0010, 8'h3C, DN);
		rd_byte(19'h2_0010, 8'h3C);
		run(`FCS_OP_BYP_EXIT, 19'h0, 8'h00, DN);
		chk(r & 32'h0000_0008, 32'h0000_0000);
		chk({31'h0, u_flash.bypass}, 32'h0000_0000);
	endtask
	task t_suspend;
		int n;
		run(`FCS_OP_SECT_ERASE, 19'h1_0000, 8'h00, 32'h0000_0000);
		for (n = 0; n < 300 && u_flash.ebusy !== 1'b1; n++)
			@(posedge clk_in);
		chk({31'h0, u_flash.ebusy}, 32'h0000_0001);
		if (n == 300)
			give_verdict;
		run(`FCS_OP_SUSPEND, 19'h0, 8'h00, 32'h0000_0020);
		chk({31'h0, u_flash.susp}, 32'h0000_0001);
		rd_byte(19'h2_0010, 8'h3C);
		rd_byte(19'h1_0123, 8'h80);
		run(`FCS_OP_RESUME, 19'h0, 8'h00, DN);
		chk(r & 32'h0000_0020, 32'h0000_0000);
		for (n = 0; n < 1000 && u_flash.ebusy !== 1'b0; n++)
			@(posedge clk_in);
		chk({31'h0, u_flash.ebusy}, 32'h0000_0000);
		if (n == 1000)
			give_verdict;
		rd_byte(19'h1_0123, 8'hFF);
		rd_byte(19'h2_0010, 8'h3C);
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 0;
		t_regs;
		t_program;
		t_autosel;
		t_bypass;
		t_suspend;
		run(`FCS_OP_CHIP_ERASE, 19'h0, 8'h00, DN);
		rd_byte(19'h2_0010, 8'hFF);
		give_verdict;
	end
endmodule // fcs_ctrl_bench
